// ---- design/vps_pkg.sv ----
// Package with constants and types for the plane read select and serializer block
package vps_pkg;

    // Indexed port addresses
    localparam logic [15:0] IDX_PORT_ADDR   = 16'h03CE;
    localparam logic [15:0] DATA_PORT_ADDR  = 16'h03CF;

    // Register indexes
    localparam logic [4:0]  IDX_READ_PLANE  = 5'h04;
    localparam logic [4:0]  IDX_GFX_MODE    = 5'h05;

    // Values after reset
    localparam logic [4:0]  INDEX_RESET     = 5'h00;
    localparam logic [1:0]  READ_PLANE_RST  = 2'h0;
    localparam logic [7:0]  GFX_MODE_RST    = 8'h00;

    // Writable bits of the graphics mode control register
    localparam logic [7:0]  GFX_MODE_MASK   = 8'h7B;

    // Field positions in graphics mode control
    localparam int          GM_SHIFT_LO     = 5;
    localparam int          GM_ODD_EVEN     = 4;
    localparam int          GM_READ_MODE    = 3;

    // Transfers per loaded set of plane bytes
    localparam logic [2:0]  XFER_LAST       = 3'h7;
    localparam logic [2:0]  XFER_FIRST      = 3'h0;

    // Four plane bytes, index is the plane number
    typedef logic [3:0][7:0] vps_planes_t;

    // Shift formats
    typedef enum logic [1:0] {
        SHIFT_BIT  = 2'b00,
        SHIFT_PAIR = 2'b01,
        SHIFT_NIB  = 2'b10,
        SHIFT_NIB2 = 2'b11
    } vps_shift_t;

    // Processor I/O request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } vps_io_req_t;

endpackage : vps_pkg

// ---- design/vps_shifter.sv ----
// Serializer turning four plane bytes into a 4-bit pixel stream
`timescale 1ns/10ps
module vps_shifter (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // Control
    input  wire logic [1:0]          shift_ctrl,
    input  wire logic                xfer,
    input  wire vps_pkg::vps_planes_t load_bytes,
    // Stream
    output logic [3:0]               pix_q,
    output logic                     load_q
);

    logic [2:0]           cnt_q;
    logic [2:0]           cnt_d;
    vps_pkg::vps_planes_t hold_q;
    vps_pkg::vps_planes_t hold_d;
    vps_pkg::vps_planes_t use_bytes;
    logic [3:0]           pix_d;
    logic                 at_first;

    function automatic logic [3:0] pix_of(input vps_pkg::vps_planes_t b,
                                          input logic [2:0] n,
                                          input logic [1:0] mode);
        logic [2:0] hi;
        logic [2:0] lo;
        logic [1:0] pl;
        hi = 3'(3'h7 - {n[1:0], 1'b0});
        lo = 3'(hi - 3'h1);
        pl = n[2] ? 2'h1 : 2'h0;
        unique case (mode)
            2'b00: pix_of = {b[3][3'(3'h7 - n)], b[2][3'(3'h7 - n)],
                             b[1][3'(3'h7 - n)], b[0][3'(3'h7 - n)]};
            2'b01: pix_of = {b[pl + 2'h2][hi], b[pl + 2'h2][lo],
                             b[pl][hi], b[pl][lo]};
            2'b10, 2'b11: pix_of = n[0] ? b[n[2:1]][3:0] : b[n[2:1]][7:4];
        endcase
    endfunction : pix_of

    // New bytes are used directly on the first transfer to avoid a bubble
    assign at_first  = (cnt_q == vps_pkg::XFER_FIRST);
    assign use_bytes = at_first ? load_bytes : hold_q;
    assign hold_d    = (xfer && at_first) ? load_bytes : hold_q;
    assign cnt_d     = xfer ? 3'(cnt_q + 3'h1) : cnt_q;
    assign pix_d     = xfer ? pix_of(use_bytes, cnt_q, shift_ctrl) : pix_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q  <= vps_pkg::XFER_FIRST;
            hold_q <= '0;
            pix_q  <= 4'h0;
            load_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            hold_q <= hold_d;
            pix_q  <= pix_d;
            load_q <= xfer && at_first;
        end
    end

    chk_bit_first_xfer: assert property (@(posedge clk_sys) disable iff (srst)
        xfer && at_first && shift_ctrl == 2'b00 |=> pix_q ==
        {$past(load_bytes[3][7]), $past(load_bytes[2][7]),
         $past(load_bytes[1][7]), $past(load_bytes[0][7])})
        else $error("bit format first pixel wrong");

    chk_pair_first_xfer: assert property (@(posedge clk_sys) disable iff (srst)
        xfer && at_first && shift_ctrl == 2'b01 |=> pix_q ==
        {$past(load_bytes[2][7:6]), $past(load_bytes[0][7:6])})
        else $error("pair format first pixel wrong");

    chk_pair_fifth_xfer: assert property (@(posedge clk_sys) disable iff (srst)
        xfer && cnt_q == 3'h4 && shift_ctrl == 2'b01 |=> pix_q ==
        {$past(hold_q[3][7:6]), $past(hold_q[1][7:6])})
        else $error("pair format plane swap wrong");

    chk_nib_order: assert property (@(posedge clk_sys) disable iff (srst)
        xfer && at_first && shift_ctrl[1] ##1 xfer && shift_ctrl[1]
        |=> pix_q == $past(hold_q[0][3:0], 1))
        else $error("nibble format lower half wrong");

    chk_load_every_8: assert property (@(posedge clk_sys) disable iff (srst)
        xfer && cnt_q == vps_pkg::XFER_LAST |=> at_first && !load_q)
        else $error("load spacing wrong");

    chk_load_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        load_q |-> $past(xfer) && $past(cnt_q) == vps_pkg::XFER_FIRST)
        else $error("load pulse without first transfer");

endmodule : vps_shifter

// ---- design/vps_top.sv ----
// Plane read select, indexed registers and serializer for the legacy display
`timescale 1ns/10ps
module vps_top (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    // Processor I/O port
    input  wire vps_pkg::vps_io_req_t io_req,
    output logic [7:0]                io_rdata_q,
    output logic                      io_rhit_q,
    // Addressing modes from the sequencer
    input  wire logic                 chain4_en,
    // Frame buffer read
    input  wire logic                 fb_rd_stb,
    input  wire logic [1:0]           fb_addr_lo,
    input  wire vps_pkg::vps_planes_t fb_planes,
    output logic [7:0]                fb_rdata_q,
    output logic                      fb_rvalid_q,
    // Latch readback
    input  wire logic                 latch_rd_stb,
    input  wire vps_pkg::vps_planes_t read_latches,
    output logic [7:0]                latch_rdata_q,
    // Mode register view for the write and compare paths
    output logic [7:0]                gfx_mode_q,
    // Serial pixel stream
    input  wire logic                 pix_xfer,
    input  wire vps_pkg::vps_planes_t pix_bytes,
    output logic [3:0]                pix_out,
    output logic                      pix_load
);

    logic [4:0]  index_q;
    logic [4:0]  index_d;
    logic [1:0]  read_plane_q;
    logic [1:0]  read_plane_d;
    logic [7:0]  gfx_mode_d;
    logic [7:0]  io_rdata_d;
    logic        io_rhit_d;
    logic [7:0]  fb_rdata_d;
    logic        fb_rvalid_d;
    logic [7:0]  latch_rdata_d;

    wire logic   sel_index   = (io_req.addr == vps_pkg::IDX_PORT_ADDR);
    wire logic   sel_data    = (io_req.addr == vps_pkg::DATA_PORT_ADDR);
    wire logic   hit_plane   = sel_data && (index_q == vps_pkg::IDX_READ_PLANE);
    wire logic   hit_mode    = sel_data && (index_q == vps_pkg::IDX_GFX_MODE);
    wire logic   odd_even_on = gfx_mode_q[vps_pkg::GM_ODD_EVEN];
    wire logic   read_cmp    = gfx_mode_q[vps_pkg::GM_READ_MODE];
    wire logic [1:0] shift_ctrl = gfx_mode_q[vps_pkg::GM_SHIFT_LO +: 2];
    logic [1:0]  fb_plane;

    // Chain-4 outranks odd/even, as the sequencer does for writes
    always_comb begin
        if (chain4_en) begin
            fb_plane = fb_addr_lo;
        end else if (odd_even_on) begin
            fb_plane = {read_plane_q[1], fb_addr_lo[0]};
        end else begin
            fb_plane = read_plane_q;
        end
    end

    // Register writes; reserved bits are dropped so they read as zero
    assign index_d      = (io_req.wr && sel_index) ? io_req.wdata[4:0] : index_q;
    assign read_plane_d = (io_req.wr && hit_plane) ? io_req.wdata[1:0] : read_plane_q;
    assign gfx_mode_d   = (io_req.wr && hit_mode)
                        ? (io_req.wdata & vps_pkg::GFX_MODE_MASK) : gfx_mode_q;

    // Other data port indexes belong to neighbouring registers, so no hit
    assign io_rhit_d  = io_req.rd && (sel_index || hit_plane || hit_mode);
    assign io_rdata_d = !io_req.rd ? io_rdata_q
                      : sel_index  ? {3'h0, index_q}
                      : hit_plane  ? {6'h00, read_plane_q}
                      : hit_mode   ? gfx_mode_q
                      : 8'h00;

    // Compare reads are answered by the colour compare path, not here
    assign fb_rvalid_d   = fb_rd_stb && !read_cmp;
    assign fb_rdata_d    = fb_rvalid_d ? fb_planes[fb_plane] : fb_rdata_q;
    assign latch_rdata_d = latch_rd_stb ? read_latches[read_plane_q] : latch_rdata_q;

    // Register file; zero reset stands in for undefined power-up contents
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            index_q      <= vps_pkg::INDEX_RESET;
            read_plane_q <= vps_pkg::READ_PLANE_RST;
            gfx_mode_q   <= vps_pkg::GFX_MODE_RST;
        end else begin
            index_q      <= index_d;
            read_plane_q <= read_plane_d;
            gfx_mode_q   <= gfx_mode_d;
        end
    end

    // Port read answer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            io_rdata_q <= 8'h00;
            io_rhit_q  <= 1'b0;
        end else begin
            io_rdata_q <= io_rdata_d;
            io_rhit_q  <= io_rhit_d;
        end
    end

    // Frame read answer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fb_rdata_q  <= 8'h00;
            fb_rvalid_q <= 1'b0;
        end else begin
            fb_rdata_q  <= fb_rdata_d;
            fb_rvalid_q <= fb_rvalid_d;
        end
    end

    // Latch readback answer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            latch_rdata_q <= 8'h00;
        end else begin
            latch_rdata_q <= latch_rdata_d;
        end
    end

    // Pixel path; outputs of the shifter are flip-flops
    vps_shifter u_shifter (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .shift_ctrl (shift_ctrl),
        .xfer       (pix_xfer),
        .load_bytes (pix_bytes),
        .pix_q      (pix_out),
        .load_q     (pix_load)
    );

    chk_plane_direct: assert property (@(posedge clk_sys) disable iff (srst)
        fb_rd_stb && !read_cmp && !chain4_en && !odd_even_on
        |=> fb_rvalid_q && fb_rdata_q == $past(fb_planes[read_plane_q]))
        else $error("direct plane read returned wrong byte");

    chk_plane_oddeven: assert property (@(posedge clk_sys) disable iff (srst)
        fb_rd_stb && !read_cmp && !chain4_en && odd_even_on
        |=> fb_rdata_q == $past(fb_planes[{read_plane_q[1], fb_addr_lo[0]}]))
        else $error("odd/even plane read returned wrong byte");

    chk_plane_chain4: assert property (@(posedge clk_sys) disable iff (srst)
        fb_rd_stb && !read_cmp && chain4_en
        |=> fb_rdata_q == $past(fb_planes[fb_addr_lo]))
        else $error("chain-4 plane read returned wrong byte");

    chk_latch_select: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.wr && hit_plane ##1 latch_rd_stb
        |=> latch_rdata_q == $past(read_latches[read_plane_q])
            && $past(read_plane_q) == $past(io_req.wdata[1:0], 2))
        else $error("latch readback used wrong select");

    chk_cmp_no_valid: assert property (@(posedge clk_sys) disable iff (srst)
        read_cmp |=> !fb_rvalid_q)
        else $error("read mode 1 answered by plane select");

    // Register port checks
    chk_index_write: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.wr && sel_index |=> index_q == $past(io_req.wdata[4:0]))
        else $error("index register write lost");

    chk_plane_write: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.wr && hit_plane |=> read_plane_q == $past(io_req.wdata[1:0]))
        else $error("plane select write lost");

    chk_mode_write: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.wr && hit_mode |=> gfx_mode_q[6:3] == $past(io_req.wdata[6:3])
            && gfx_mode_q[1:0] == $past(io_req.wdata[1:0]) && !gfx_mode_q[7] && !gfx_mode_q[2])
        else $error("mode register write wrong");

    chk_index_readback: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.rd && sel_index |=> io_rhit_q && io_rdata_q == {3'h0, $past(index_q)})
        else $error("index readback wrong");

    chk_plane_readback: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.rd && hit_plane |=> io_rhit_q && io_rdata_q == {6'h00, $past(read_plane_q)})
        else $error("plane select readback wrong");

    chk_mode_readback: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.rd && hit_mode |=> io_rhit_q && io_rdata_q == $past(gfx_mode_q))
        else $error("mode register readback wrong");

    chk_refused_read: assert property (@(posedge clk_sys) disable iff (srst)
        io_req.rd && !sel_index && !hit_plane && !hit_mode |=> !io_rhit_q && io_rdata_q == 8'h00)
        else $error("foreign port read answered");

    // Answer hold checks
    chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !io_req.rd |=> !io_rhit_q && $stable(io_rdata_q))
        else $error("port read data moved without read");

    chk_fb_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !(fb_rd_stb && !read_cmp) |=> !fb_rvalid_q && $stable(fb_rdata_q))
        else $error("frame read data moved without answered read");

    chk_latch_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !latch_rd_stb |=> $stable(latch_rdata_q))
        else $error("latch readback moved without strobe");

endmodule : vps_top

// ---- verification/vps_plane_mem.sv ----
// Frame buffer plane model answering processor reads
`timescale 1ns/10ps
module vps_plane_mem (
    // Read request
    input  wire logic           fb_rd_stb,
    input  wire logic [1:0]     fb_addr_lo,
    // Plane bytes, valid only while read
    output vps_pkg::vps_planes_t fb_planes
);
    // Idle memory shows the inverse, so stale sampling never matches
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            fb_planes[k] = {2'(k), fb_addr_lo, ~2'(k), ~fb_addr_lo};
            if (!fb_rd_stb) fb_planes[k] = ~fb_planes[k];
        end
    end
endmodule : vps_plane_mem

// ---- verification/vps_top_tb.sv ----
// Self-checking testbench for the plane read select and serializer
`timescale 1ns/10ps
module vps_top_tb;
    logic                 clk_sys, srst, io_rhit_q, fb_rvalid_q, pix_load, pix_xfer;
    logic                 chain4_en, fb_rd_stb, latch_rd_stb, oe, lat_p, pix_p;
    vps_pkg::vps_io_req_t io_req;
    vps_pkg::vps_planes_t fb_planes, read_latches, pix_bytes, b;
    logic [7:0]           io_rdata_q, fb_rdata_q, latch_rdata_q, gfx_mode_q, gm;
    logic [3:0]           pix_out;
    logic [1:0]           fb_addr_lo, sel;
    logic [7:0]           q_io[$], q_fb[$], q_lat[$], q_pix[$];
    int                   n_fail, check_count, cyc;
    localparam logic [15:0] IA = vps_pkg::IDX_PORT_ADDR;
    localparam logic [15:0] DA = vps_pkg::DATA_PORT_ADDR;

    vps_top DUT (.clk_sys(clk_sys), .srst(srst), .io_req(io_req), .io_rdata_q(io_rdata_q),
        .io_rhit_q(io_rhit_q), .chain4_en(chain4_en), .fb_rd_stb(fb_rd_stb),
        .fb_addr_lo(fb_addr_lo), .fb_planes(fb_planes), .fb_rdata_q(fb_rdata_q),
        .fb_rvalid_q(fb_rvalid_q), .latch_rd_stb(latch_rd_stb), .read_latches(read_latches),
        .latch_rdata_q(latch_rdata_q), .gfx_mode_q(gfx_mode_q), .pix_xfer(pix_xfer),
        .pix_bytes(pix_bytes), .pix_out(pix_out), .pix_load(pix_load));
    vps_plane_mem u_mem (.fb_rd_stb(fb_rd_stb), .fb_addr_lo(fb_addr_lo), .fb_planes(fb_planes));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    function automatic logic [3:0] px(input vps_pkg::vps_planes_t v, input int k, input int m);
        int j;
        j = 6 - 2 * (k % 4);
        if (m == 0) return {v[3][7-k], v[2][7-k], v[1][7-k], v[0][7-k]};
        if (m == 1) return {v[2+k/4][j+1], v[2+k/4][j], v[k/4][j+1], v[k/4][j]};
        return (k % 2) ? v[k/2][3:0] : v[k/2][7:4];
    endfunction : px

    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_sys);
        io_req = '0;
    endtask : io

    // Refused reads push nothing, so a stray hit is checked against x and fails
    task automatic rd(input logic [15:0] a, input logic hit, input logic [7:0] e);
        if (hit) q_io.push_back(e);
        io(1'b0, a, 8'h00);
    endtask : rd

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
        io(1'b1, IA, idx);
        io(1'b1, DA, v);
    endtask : reg_wr

    task automatic set_mode(input logic [1:0] sh, input logic o, input logic r);
        gm = {1'b0, sh, o, r, 1'b0, 2'($urandom_range(3))};
        oe = o;
        reg_wr(8'h05, gm);
        chk(gfx_mode_q, gm);
    endtask : set_mode

    task automatic fbr(input logic [1:0] a);
        logic [1:0] p;
        p = chain4_en ? a : (oe ? {sel[1], a[0]} : sel);
        if (!gm[3]) q_fb.push_back({p, a, ~p, ~a});
        @(negedge clk_sys);
        fb_rd_stb = 1'b1;
        fb_addr_lo = a;
        @(negedge clk_sys);
        fb_rd_stb = 1'b0;
    endtask : fbr

    always @(posedge clk_sys) begin
        lat_p = latch_rd_stb;
        pix_p = pix_xfer;
        #1;
        if (io_rhit_q !== 1'b0) chk(io_rdata_q, q_io.size() ? q_io.pop_front() : 'x);
        if (fb_rvalid_q !== 1'b0) chk(fb_rdata_q, q_fb.size() ? q_fb.pop_front() : 'x);
        if (lat_p) chk(latch_rdata_q, q_lat.pop_front());
        if (pix_p) chk({3'h0, pix_load, pix_out}, q_pix.pop_front());
    end

    // Whole run needs well under 2000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(8560));
        {srst, io_req, chain4_en, fb_rd_stb, fb_addr_lo, latch_rd_stb} = '1;
        {io_req, chain4_en, fb_rd_stb, latch_rd_stb, pix_xfer, pix_bytes, read_latches} = '0;
        {fb_addr_lo, sel, oe, gm} = '0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        rd(DA, 1'b0, 8'h00);
        io(1'b1, IA, 8'h04);
        rd(DA, 1'b1, 8'h00);
        io(1'b1, IA, 8'h05);
        rd(DA, 1'b1, 8'h00);
        rd(IA, 1'b1, 8'h05);
        rd(16'h03CD, 1'b0, 8'h00);
        reg_wr(8'h05, 8'hFF);
        rd(DA, 1'b1, 8'h7B);
        reg_wr(8'h04, 8'hFF);
        rd(DA, 1'b1, 8'h03);
        reg_wr(8'h06, 8'h55);
        rd(DA, 1'b0, 8'h00);
        io(1'b1, IA, 8'hFF);
        rd(IA, 1'b1, 8'h1F);
        for (int c = 0; c < 2; c++) for (int o = 0; o < 2; o++) begin
            chain4_en = c[0];
            set_mode(2'b00, o[0], 1'b0);
            for (int s = 0; s < 4; s++) begin
                sel = s[1:0];
                reg_wr(8'h04, {6'h00, sel});
                for (int a = 0; a < 4; a++) fbr(a[1:0]);
            end
        end
        set_mode(2'b00, 1'b0, 1'b1);
        fbr(2'd1);
        set_mode(2'b00, 1'b0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            reg_wr(8'h04, {6'h00, sel});
            read_latches = $urandom;
            latch_rd_stb = 1'b1;
            q_lat.push_back(read_latches[sel]);
            @(negedge clk_sys);
            latch_rd_stb = 1'b0;
        end
        for (int m = 0; m < 4; m++) begin
            set_mode(m[1:0], 1'b0, 1'b0);
            for (int g = 0; g < 2; g++) begin
                b = $urandom;
                pix_bytes = b;
                for (int k = 0; k < 8; k++) begin
                    @(negedge clk_sys);
                    pix_xfer = 1'b1;
                    if (k == 1) pix_bytes = ~b;
                    q_pix.push_back({3'h0, k == 0, px(b, k, m)});
                end
                @(negedge clk_sys);
                pix_xfer = 1'b0;
            end
        end
        repeat (3) @(negedge clk_sys);
        chk(8'(q_io.size() + q_fb.size() + q_lat.size() + q_pix.size()), 8'h00);
        end_sim();
    end
endmodule : vps_top_tb
